// ==== inc/wit_pkg.sv ====
// wit_pkg.sv - constants and types for the wake-up interval timer and power-state control
package wit_pkg;

   // sfr addresses
   localparam logic [7:0] ADDR_PRECOUNT_LOW  = 8'hBA;
   localparam logic [7:0] ADDR_PRECOUNT_HIGH = 8'hBB;
   localparam logic [7:0] ADDR_WAKE_PERIOD   = 8'hBC;
   localparam logic [7:0] ADDR_POWER_STATE   = 8'hF8;
   localparam logic [7:0] ADDR_TIMER_STATUS  = 8'hE8;

   // reset values
   localparam logic [7:0] RST_PRECOUNT_LOW  = 8'hE8;
   localparam logic [3:0] RST_PRECOUNT_HIGH = 4'h3;
   localparam logic [7:0] RST_WAKE_PERIOD   = 8'h01;
   localparam logic [7:0] RST_POWER_STATE   = 8'h00;

   // field positions
   localparam int POS_ENTER_POWERDOWN  = 7;
   localparam int POS_ENTER_IDLE       = 5;
   localparam int POS_SYSCLK_SELECT    = 0;
   localparam int POS_RELOAD_PENDING   = 1;
   localparam int POS_COUNTDOWN_ON     = 0;
   localparam logic [7:0] POWER_STATE_MASK = 8'hA1;

   // lp oscillator rate and tick-enable divider from the system clock
   localparam int LP_OSC_HZ     = 2000;
   localparam int SYS_CLK_HZ    = 10_000_000;
   localparam int LP_TICK_DIV   = SYS_CLK_HZ / LP_OSC_HZ;

   // cycles of the lp tick between a register write and reload taking effect
   localparam logic [1:0] RELOAD_DELAY_TICKS = 2'h2;

   typedef enum logic [1:0] {
      WIT_RUN,
      WIT_IDLE,
      WIT_POWERDOWN
   } wit_pstate_e;

endpackage : wit_pkg

// ==== logic/wit_counter.sv ====
// wit_counter.sv - precounter and postcounter chain clocked by the lp tick
module wit_counter #(
   parameter int PRE_W  = 12,
   parameter int POST_W = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   // control
   input  wire logic              tick,
   input  wire logic              run,
   input  wire logic              load,
   input  wire logic [PRE_W-1:0]  pre_val,
   input  wire logic [POST_W-1:0] post_val,
   // result
   output logic                   expire
);
   logic [PRE_W-1:0]  pre_q;
   logic [POST_W-1:0] post_q;
   logic              expire_q;

   wire pre_end  = (pre_q <= {{(PRE_W-1){1'b0}}, 1'b1});
   // post value 0 wraps through all 256 states, giving a multiplier of 256
   wire post_end = (post_q == {{(POST_W-1){1'b0}}, 1'b1});

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre_q    <= '0;
         post_q   <= '0;
         expire_q <= 1'b0;
      end
      else if (ce)
      begin
         expire_q <= 1'b0;
         if (load)
         begin
            pre_q  <= pre_val;
            post_q <= post_val;
         end
         else if (tick && run)
         begin
            if (!pre_end)
               pre_q <= pre_q - 1'b1;
            else
            begin
               pre_q <= pre_val;
               if (post_end)
               begin
                  post_q   <= post_val;
                  expire_q <= 1'b1;
               end
               else
                  post_q <= post_q - 1'b1;
            end
         end
      end
   end

   assign expire = expire_q;

endmodule : wit_counter

// ==== logic/wit_top.sv ====
// wit_top.sv - wake-up interval timer with power-state control register
//
// Summary of operation
// - precount high register holds bits 11..8 low nibble; upper nibble reserved; reset 0x03.
// - precount low register holds bits 7..0, read-write, reset 0xE8.
// - eight-bit read-write period register holds postcounter value, reset 0x01.
// - after power-down wake-up, high register upper nibble zero, low nibble kept.
// - after power-down wake-up, low precount and period registers keep their values.
// - timer uses whatever values software writes, calibrated or not.
// - bit 7 of power-state enters power down; hardware clears it on wake-up.
// - bit 5 of power-state enters idle; hardware clears it on resume event.
// - bit 0 selects system clock: 0 internal RC, 1 crystal; reset 0x00.
// - period value 0x00 multiplies by 256; 0x01..0xFF by 1..255.
// - interval is precounter over 2 kHz times postcounter; timer runs on lp ticks.
// - normal mode always counts; disabling only in test, debug or programming modes.
module wit_top
   import wit_pkg::*;
#(
   parameter int LP_DIV = LP_TICK_DIV
) (
   // clock, reset, enable
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   input  wire logic       CE,
   // sfr access
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   // mode and events
   input  wire logic       NORMAL_MODE,
   input  wire logic       TEST_TIMER_OFF,
   input  wire logic       RESUME_EVENT,
   input  wire logic       EXT_WAKE,
   // system controls
   output logic            POWERDOWN_REQ,
   output logic            IDLE_REQ,
   output logic            SYSCLK_XTAL_SEL,
   output logic            INTERVAL_WAKE
);
   import wit_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]       pre_lo_q;
   logic [3:0]       pre_hi_q;
   logic [7:0]       period_q;
   logic             enter_powerdown_q;
   logic             idle_q;
   logic             clksel_q;
   logic             pending_q;
   logic [1:0]       pend_cnt_q;
   logic [15:0]      div_q;
   logic [7:0]       rdata_q;
   logic [7:0]       rd_mux;
   logic             expire;
   logic             wake_ev;

   wire wr_lo  = SFR_WR && (SFR_ADDR == ADDR_PRECOUNT_LOW);
   wire wr_hi  = SFR_WR && (SFR_ADDR == ADDR_PRECOUNT_HIGH);
   wire wr_per = SFR_WR && (SFR_ADDR == ADDR_WAKE_PERIOD);
   wire wr_ps  = SFR_WR && (SFR_ADDR == ADDR_POWER_STATE);
   wire tick   = (div_q == 16'h0000);
   wire run    = NORMAL_MODE || !TEST_TIMER_OFF;
   wire load   = pending_q && tick && (pend_cnt_q == 2'h0);

   // wake from power down by any enabled source, the interval among them
   assign wake_ev = enter_powerdown_q && (expire || EXT_WAKE);

   // ------------------------------------------------------------
   // timer registers
   // ------------------------------------------------------------
   // wake-up leaves every timer bit intact; only a system reset restores them
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pre_lo_q <= RST_PRECOUNT_LOW;
         pre_hi_q <= RST_PRECOUNT_HIGH;
         period_q <= RST_WAKE_PERIOD;
      end
      else if (CE)
      begin
         if (wr_lo)
            pre_lo_q <= SFR_WDATA;
         if (wr_hi)
            pre_hi_q <= SFR_WDATA[3:0];
         if (wr_per)
            period_q <= SFR_WDATA;
      end
   end

   // ------------------------------------------------------------
   // power-state control
   // ------------------------------------------------------------
   // a software write wins over a same-cycle hardware clear, so a fresh
   // power-down request is never lost to a wake already under way
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         enter_powerdown_q   <= RST_POWER_STATE[POS_ENTER_POWERDOWN];
         idle_q   <= RST_POWER_STATE[POS_ENTER_IDLE];
         clksel_q <= RST_POWER_STATE[POS_SYSCLK_SELECT];
      end
      else if (CE)
      begin
         if (wr_ps)
         begin
            enter_powerdown_q   <= SFR_WDATA[POS_ENTER_POWERDOWN];
            idle_q   <= SFR_WDATA[POS_ENTER_IDLE];
            clksel_q <= SFR_WDATA[POS_SYSCLK_SELECT];
         end
         else
         begin
            if (wake_ev)
               enter_powerdown_q <= 1'b0;
            if (RESUME_EVENT)
               idle_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // lp time base and reload handshake
   // ------------------------------------------------------------
   // a divider of the system clock stands in for the lp oscillator
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         div_q <= 16'h0000;
      else if (CE)
      begin
         if (tick)
            div_q <= 16'(LP_DIV - 1);
         else
            div_q <= div_q - 16'h0001;
      end
   end

   // a write restarts the wait so the last written value is the one loaded
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         pending_q <= 1'b1;
      else if (CE)
      begin
         if (wr_lo || wr_hi || wr_per)
            pending_q <= 1'b1;
         else if (load)
            pending_q <= 1'b0;
      end
   end

   // wait counter steps on lp ticks only while a reload is pending
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         pend_cnt_q <= RELOAD_DELAY_TICKS;
      else if (CE)
      begin
         if (wr_lo || wr_hi || wr_per)
            pend_cnt_q <= RELOAD_DELAY_TICKS;
         else if (pending_q && tick && (pend_cnt_q != 2'h0))
            pend_cnt_q <= pend_cnt_q - 2'h1;
      end
   end

   wit_counter #(
      .PRE_W  (12),
      .POST_W (8)
   ) u_counter (
      .clk      (CLK),
      .arst_n   (ARST_N),
      .ce       (CE),
      .tick     (tick),
      .run      (run),
      .load     (load),
      .pre_val  ({pre_hi_q, pre_lo_q}),
      .post_val (period_q),
      .expire   (expire)
   );

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // registered read data holds until the next read strobe
   always_comb
   begin
      rd_mux = 8'h00;
      case (SFR_ADDR)
         ADDR_PRECOUNT_LOW:  rd_mux = pre_lo_q;
         ADDR_PRECOUNT_HIGH: rd_mux = {4'h0, pre_hi_q};
         ADDR_WAKE_PERIOD:   rd_mux = period_q;
         ADDR_POWER_STATE:   rd_mux = {enter_powerdown_q, 1'b0, idle_q, 4'h0, clksel_q};
         ADDR_TIMER_STATUS:
         begin
            rd_mux[POS_RELOAD_PENDING] = pending_q;
            rd_mux[POS_COUNTDOWN_ON]   = run;
         end
         default:            rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         rdata_q <= 8'h00;
      else if (CE && SFR_RD)
         rdata_q <= rd_mux;
   end

   assign SFR_RDATA       = rdata_q;
   assign POWERDOWN_REQ   = enter_powerdown_q;
   assign IDLE_REQ        = idle_q;
   assign SYSCLK_XTAL_SEL = clksel_q;
   assign INTERVAL_WAKE   = expire;

endmodule : wit_top

// ==== dv/wit_chk.sv ====
// wit_chk.sv - port assertions for wit_top
module wit_chk
   import wit_pkg::*;
(
   input wire logic       CLK,
   input wire logic       ARST_N,
   input wire logic       CE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       RESUME_EVENT,
   input wire logic       EXT_WAKE,
   input wire logic       POWERDOWN_REQ,
   input wire logic       IDLE_REQ,
   input wire logic       SYSCLK_XTAL_SEL,
   input wire logic       INTERVAL_WAKE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       wr_ps;
   logic       rd_hi;
   logic [7:0] ps_view;
   assign wr_ps = CE && SFR_WR && SFR_ADDR == ADDR_POWER_STATE;
   assign rd_hi = CE && SFR_RD && SFR_ADDR == ADDR_PRECOUNT_HIGH;
   assign ps_view = {POWERDOWN_REQ, 1'b0, IDLE_REQ, 4'h0, SYSCLK_XTAL_SEL};
   // ----------
   // assertions
   // ----------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   a_pd_write: assert property (wr_ps |=> POWERDOWN_REQ == $past(SFR_WDATA[7]))
      else $error("pd write");
   a_idle_write: assert property (wr_ps |=> IDLE_REQ == $past(SFR_WDATA[5]))
      else $error("idle write");
   a_sel_write: assert property (wr_ps |=> SYSCLK_XTAL_SEL == $past(SFR_WDATA[0]))
      else $error("clock select write");
   a_idle_clear: assert property (IDLE_REQ && RESUME_EVENT && CE && !wr_ps |=> !IDLE_REQ)
      else $error("idle not cleared");
   a_pd_ext: assert property (POWERDOWN_REQ && EXT_WAKE && CE && !wr_ps |=> !POWERDOWN_REQ)
      else $error("pd not cleared");
   a_wake_pulse: assert property (INTERVAL_WAKE |=> !INTERVAL_WAKE)
      else $error("wake pulse too long");
   a_high_rsvd: assert property (rd_hi |=> SFR_RDATA[7:4] == 4'h0)
      else $error("high nibble not zero");
   a_ps_read: assert property (CE && SFR_RD && SFR_ADDR == ADDR_POWER_STATE && !wr_ps
      |=> SFR_RDATA == $past(ps_view))
      else $error("power state readback");
   c_wake: cover property (INTERVAL_WAKE);
   c_pd_done: cover property ($fell(POWERDOWN_REQ));
   c_idle_done: cover property ($fell(IDLE_REQ));
endmodule : wit_chk

bind wit_top wit_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .SFR_ADDR(SFR_ADDR),
   .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
   .RESUME_EVENT(RESUME_EVENT), .EXT_WAKE(EXT_WAKE), .POWERDOWN_REQ(POWERDOWN_REQ),
   .IDLE_REQ(IDLE_REQ), .SYSCLK_XTAL_SEL(SYSCLK_XTAL_SEL), .INTERVAL_WAKE(INTERVAL_WAKE));

// ==== dv/wit_top_tb.sv ====
// wit_top_tb.sv - self-checking bench for wit_top
module wit_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import wit_pkg::*;
   localparam int DIV = 4;
   logic        clk, arst_n, ce, wr, rd, md, off, res, ext, pd, idl, sel, wake;
   logic [7:0]  a, d, rdata, q;
   int          n, err_count, check_count;
   // address, write data, expected readback
   logic [23:0] rows [9] = '{24'hBA_A5A5, 24'hBB_F606, 24'hBC_0000, 24'hF8_FFA1,
      24'hF8_5E00, 24'h50_FF00, 24'hBA_FFFF, 24'hBB_FF0F, 24'hBC_FFFF};
   logic [15:0] keep [3] = '{16'hBB01, 16'hBA00, 16'hBC03};
   logic [15:0] rst_rows [4] = '{16'hBAE8, 16'hBB03, 16'hBC01, 16'hF800};
   wit_top #(.LP_DIV(DIV)) uut (.CLK(clk), .ARST_N(arst_n), .CE(ce), .SFR_ADDR(a),
      .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(d), .SFR_RDATA(rdata), .NORMAL_MODE(md),
      .TEST_TIMER_OFF(off), .RESUME_EVENT(res), .EXT_WAKE(ext), .POWERDOWN_REQ(pd),
      .IDLE_REQ(idl), .SYSCLK_XTAL_SEL(sel), .INTERVAL_WAKE(wake));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic wr_reg(input logic [7:0] ad, dd);
      @(negedge clk);
      {a, d, wr} = {ad, dd, 1'b1};
      @(negedge clk);
      wr = 0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] ad);
      @(negedge clk);
      {a, rd} = {ad, 1'b1};
      @(negedge clk);
      rd = 0;
      q = rdata;
   endtask : rd_reg
   task automatic rdv(input logic [15:0] r);
      rd_reg(r[15:8]);
      chk("read", q, r[7:0]);
   endtask : rdv
   // bounded wait for the next wake pulse; n returns the cycles waited
   task automatic ww(input int lim);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (wake !== 1'b1 && n < lim);
      chk("wake", wake, 1'b1);
      if (wake !== 1'b1)
         complete_run();
   endtask : ww
   task automatic cfg(input logic [7:0] h, l, p);
      wr_reg(ADDR_PRECOUNT_HIGH, h);
      wr_reg(ADDR_PRECOUNT_LOW, l);
      wr_reg(ADDR_WAKE_PERIOD, p);
      rd_reg(ADDR_TIMER_STATUS);
      chk("pending", q[1], 1'b1);
      for (int i = 0; i < 20 && q[1] !== 1'b0; i++)
         rd_reg(ADDR_TIMER_STATUS);
      chk("reloaded", q[1], 1'b0);
      if (q[1] !== 1'b0)
         complete_run();
   endtask : cfg
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      {arst_n, wr, rd, off, res, ext, a, d, err_count, check_count} = '0;
      md = 1;
      ce = 1;
      repeat (8) @(negedge clk);
      arst_n = 1;
      foreach (rows[i])
      begin
         wr_reg(rows[i][23:16], rows[i][15:8]);
         rd_reg(rows[i][23:16]);
         chk("reg", q, rows[i][7:0]);
         if (rows[i][23:16] == ADDR_POWER_STATE)
            chk("outs", {pd, idl, sel}, {rows[i][15], rows[i][13], rows[i][8]});
      end
      // timer off request is ignored while in normal mode
      off = 1;
      cfg(8'h00, 8'h01, 8'h00);
      chk("count on", q[0], 1'b1);
      ww(2000);
      ww(2000);
      chk("period n0", n, 256 * DIV);
      cfg(8'h01, 8'h00, 8'h03);
      ww(4000);
      ww(4000);
      chk("period", n, 256 * 3 * DIV);
      wr_reg(ADDR_POWER_STATE, 8'h80);
      chk("pd on", pd, 1'b1);
      ww(4000);
      @(negedge clk);
      chk("pd woke", pd, 1'b0);
      foreach (keep[i]) rdv(keep[i]);
      wr_reg(ADDR_POWER_STATE, 8'h80);
      ext = 1;
      @(negedge clk);
      ext = 0;
      chk("pd ext", pd, 1'b0);
      wr_reg(ADDR_POWER_STATE, 8'h20);
      chk("idle on", idl, 1'b1);
      res = 1;
      @(negedge clk);
      res = 0;
      chk("idle off", idl, 1'b0);
      md = 0;
      rd_reg(ADDR_TIMER_STATUS);
      chk("count off", q[0], 1'b0);
      n = 0;
      repeat (3200) @(negedge clk) n += wake;
      chk("no wake", n, 0);
      // a write while the clock enable is low must not land
      ce = 0;
      wr_reg(ADDR_WAKE_PERIOD, 8'h5A);
      ce = 1;
      rdv(16'hBC03);
      // outside normal mode the timer counts unless the test input stops it
      off = 0;
      rd_reg(ADDR_TIMER_STATUS);
      chk("test run", q[0], 1'b1);
      arst_n = 0;
      @(negedge clk);
      arst_n = 1;
      foreach (rst_rows[i]) rdv(rst_rows[i]);
      chk("outs", {pd, idl, sel}, 3'h0);
      complete_run();
   end
endmodule : wit_top_tb
